// ---- range_refresh_rate_pin_control.sv ----
// Range settings, refresh command decode and rate-override pin monitor.
// Assumes a link-side front end issuing one access at a time on link_clk_in.
`timescale 1ns/1ps
`default_nettype none
module range_refresh_rate_pin_control #(
  parameter logic [range_refresh_pkg::WAIT_W-1:0] RESULT_WAIT =
    range_refresh_pkg::RESULT_WAIT_CYCLES
) (
  // Core clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // Link clock and reset
  input  wire logic        link_clk_in,
  input  wire logic        link_reset_n_in,
  // Link access request
  input  wire logic        acc_req_in,
  input  wire logic [1:0]  acc_kind_in,
  input  wire logic [7:0]  acc_addr_in,
  input  wire logic [15:0] acc_wdata_in,
  // Link access answer
  output logic             acc_busy_out,
  output logic             acc_done_out,
  output logic [15:0]      acc_rdata_out,
  // Rate-override pin
  input  wire logic        rate_pin_in,
  // Conversion engine controls
  output logic             results_update_out,
  output logic             accum_clear_out,
  output logic             pending_activate_out,
  output logic             results_ready_out,
  output logic [15:0]      active_range_out,
  output logic [3:0]       sense_bipolar_out,
  output logic [3:0]       sense_half_out,
  output logic [3:0]       busv_bipolar_out,
  output logic [3:0]       busv_half_out
);
  // ==========================================================
  // Declarations
  logic        busy_ff;
  logic        done_ff;
  logic [15:0] link_rdata_ff;
  logic [1:0]  hold_kind_ff;
  logic [7:0]  hold_addr_ff;
  logic [15:0] hold_wdata_ff;
  logic        req_tgl_ff;
  logic        ack_sync1_ff;
  logic        ack_sync2_ff;
  logic        ack_seen_ff;
  logic        req_sync1_ff;
  logic        req_sync2_ff;
  logic        req_seen_ff;
  logic        ack_tgl_ff;
  logic [15:0] core_rdata_ff;
  logic        pin_sync1_ff;
  logic        pin_sync2_ff;
  logic        pin_prev_ff;
  logic [15:0] range_cfg_ff;
  logic [15:0] active_range_ff;
  logic [3:0]  rate_en_ff;
  logic        rise_flag_ff;
  logic        fall_flag_ff;
  logic        update_ff;
  logic        clear_ff;
  logic        activate_ff;
  logic        ready_ff;
  logic [range_refresh_pkg::WAIT_W-1:0] wait_cnt_ff;
  logic [range_refresh_pkg::WAIT_W-1:0] nxt_wait_cnt;
  logic        ack_new;
  logic        req_new;
  logic        is_read;
  logic        is_write;
  logic        is_send;
  logic        cmd_full;
  logic        cmd_reset;
  logic        pin_rise;
  logic        pin_fall;
  logic        lim_reset;
  logic        lim_retain;
  logic        do_update;
  logic        wr_range;
  logic        wr_rate;

  // Maps a range field to {bipolar, half scale}; the reserved code acts as default.
  function automatic logic [1:0] decode_range(input logic [1:0] code);
    case (code)
      range_refresh_pkg::RANGE_BIPOLAR_FULL: decode_range = 2'b10;
      range_refresh_pkg::RANGE_BIPOLAR_HALF: decode_range = 2'b11;
      default:                               decode_range = 2'b00;
    endcase
  endfunction : decode_range

  // ==========================================================
  // Link domain: request capture and answer return
  // Hold registers stay still until the core acknowledges, so the core may
  // sample them directly once the request toggle has crossed.
  assign ack_new = ack_sync2_ff ^ ack_seen_ff;

  always_ff @(posedge link_clk_in or negedge link_reset_n_in) begin
    if (!link_reset_n_in) begin
      busy_ff       <= 1'b0;
      req_tgl_ff    <= 1'b0;
      hold_kind_ff  <= 2'b00;
      hold_addr_ff  <= 8'h00;
      hold_wdata_ff <= 16'h0000;
    end else if (!busy_ff && acc_req_in) begin
      busy_ff       <= 1'b1;
      req_tgl_ff    <= ~req_tgl_ff;
      hold_kind_ff  <= acc_kind_in;
      hold_addr_ff  <= acc_addr_in;
      hold_wdata_ff <= acc_wdata_in;
    end else if (busy_ff && ack_new) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in or negedge link_reset_n_in) begin
    if (!link_reset_n_in) begin
      ack_sync1_ff  <= 1'b0;
      ack_sync2_ff  <= 1'b0;
      ack_seen_ff   <= 1'b0;
      done_ff       <= 1'b0;
      link_rdata_ff <= 16'h0000;
    end else begin
      ack_sync1_ff <= ack_tgl_ff;
      ack_sync2_ff <= ack_sync1_ff;
      ack_seen_ff  <= ack_sync2_ff;
      done_ff      <= busy_ff && ack_new;
      if (busy_ff && ack_new) begin
        link_rdata_ff <= core_rdata_ff;
      end
    end
  end

  assign acc_busy_out  = busy_ff;
  assign acc_done_out  = done_ff;
  assign acc_rdata_out = link_rdata_ff;

  // ==========================================================
  // Core domain: request crossing and decode
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_sync1_ff <= 1'b0;
      req_sync2_ff <= 1'b0;
      req_seen_ff  <= 1'b0;
      ack_tgl_ff   <= 1'b0;
    end else begin
      req_sync1_ff <= req_tgl_ff;
      req_sync2_ff <= req_sync1_ff;
      req_seen_ff  <= req_sync2_ff;
      if (req_new) begin
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  assign req_new  = req_sync2_ff ^ req_seen_ff;
  assign is_read  = req_new && (hold_kind_ff == range_refresh_pkg::ACC_READ);
  assign is_write = req_new && (hold_kind_ff == range_refresh_pkg::ACC_WRITE);
  assign is_send  = req_new && (hold_kind_ff == range_refresh_pkg::ACC_SEND);
  assign wr_range = is_write && (hold_addr_ff == range_refresh_pkg::RANGE_CFG_ADDR);
  assign wr_rate  = is_write && (hold_addr_ff == range_refresh_pkg::RATE_PIN_ADDR);
  // Global refresh is decoded alike whether it came addressed or as General Call.
  assign cmd_reset = is_send && ((hold_addr_ff == range_refresh_pkg::PLAIN_REFRESH_ADDR) ||
                     (hold_addr_ff == range_refresh_pkg::GLOBAL_REFRESH_ADDR));
  assign cmd_full  = cmd_reset || (is_send &&
                     (hold_addr_ff == range_refresh_pkg::RETAIN_REFRESH_ADDR));

  // ==========================================================
  // Rate-override pin
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_sync1_ff <= 1'b0;
      pin_sync2_ff <= 1'b0;
      pin_prev_ff  <= 1'b0;
    end else begin
      pin_sync1_ff <= rate_pin_in;
      pin_sync2_ff <= pin_sync1_ff;
      pin_prev_ff  <= pin_sync2_ff;
    end
  end

  assign pin_rise   = pin_sync2_ff && !pin_prev_ff;
  assign pin_fall   = !pin_sync2_ff && pin_prev_ff;
  assign lim_reset  = (pin_rise && rate_en_ff[range_refresh_pkg::RISE_RESET_EN]) ||
                      (pin_fall && rate_en_ff[range_refresh_pkg::FALL_RESET_EN]);
  // The resetting kind masks the retaining one on the same edge.
  assign lim_retain = !lim_reset &&
                      ((pin_rise && rate_en_ff[range_refresh_pkg::RISE_RETAIN_EN]) ||
                       (pin_fall && rate_en_ff[range_refresh_pkg::FALL_RETAIN_EN]));
  assign do_update  = cmd_full || lim_reset || lim_retain;

  // ==========================================================
  // Rate register: enables, edge flags
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rate_en_ff <= range_refresh_pkg::RATE_EN_RESET;
    end else if (wr_rate) begin
      rate_en_ff <= hold_wdata_ff[range_refresh_pkg::EN_FIELD_LSB +: 4];
    end
  end

  // A pin edge in the clearing cycle wins, so no transition is ever lost.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_flag_ff <= 1'b0;
      fall_flag_ff <= 1'b0;
    end else begin
      if (pin_rise) begin
        rise_flag_ff <= 1'b1;
      end else if (cmd_reset) begin
        rise_flag_ff <= 1'b0;
      end
      if (pin_fall) begin
        fall_flag_ff <= 1'b1;
      end else if (cmd_reset) begin
        fall_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Range registers: pending and active
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      range_cfg_ff    <= range_refresh_pkg::RANGE_CFG_RESET;
      active_range_ff <= range_refresh_pkg::RANGE_CFG_RESET;
    end else begin
      if (wr_range) begin
        range_cfg_ff <= hold_wdata_ff;
      end
      if (cmd_full) begin
        active_range_ff <= range_cfg_ff;
      end
    end
  end

  assign active_range_out = active_range_ff;

  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    logic [1:0] sense_mode_ff;
    logic [1:0] busv_mode_ff;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        sense_mode_ff <= 2'b00;
        busv_mode_ff  <= 2'b00;
      end else if (cmd_full) begin
        sense_mode_ff <= decode_range(
          range_cfg_ff[range_refresh_pkg::SENSE_FIELD_TOP - 2*ch -: 2]);
        busv_mode_ff  <= decode_range(
          range_cfg_ff[range_refresh_pkg::BUSV_FIELD_TOP - 2*ch -: 2]);
      end
    end
    assign sense_bipolar_out[ch] = sense_mode_ff[1];
    assign sense_half_out[ch]    = sense_mode_ff[0];
    assign busv_bipolar_out[ch]  = busv_mode_ff[1];
    assign busv_half_out[ch]     = busv_mode_ff[0];
  end

  // ==========================================================
  // Refresh strobes and result readiness
  always_comb begin
    if (do_update) begin
      nxt_wait_cnt = RESULT_WAIT;
    end else if (wait_cnt_ff != '0) begin
      nxt_wait_cnt = wait_cnt_ff - 1'b1;
    end else begin
      nxt_wait_cnt = wait_cnt_ff;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      update_ff   <= 1'b0;
      clear_ff    <= 1'b0;
      activate_ff <= 1'b0;
      wait_cnt_ff <= '0;
      ready_ff    <= 1'b0;
    end else begin
      update_ff   <= do_update;
      clear_ff    <= cmd_reset || lim_reset;
      activate_ff <= cmd_full;
      wait_cnt_ff <= nxt_wait_cnt;
      ready_ff    <= (nxt_wait_cnt == '0);
    end
  end

  assign results_update_out   = update_ff;
  assign accum_clear_out      = clear_ff;
  assign pending_activate_out = activate_ff;
  assign results_ready_out    = ready_ff;

  // ==========================================================
  // Register reads; unmapped offsets and command codes read as zero
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_rdata_ff <= 16'h0000;
    end else if (is_read) begin
      case (hold_addr_ff)
        range_refresh_pkg::RANGE_CFG_ADDR:    core_rdata_ff <= range_cfg_ff;
        range_refresh_pkg::ACTIVE_RANGE_ADDR: core_rdata_ff <= active_range_ff;
        range_refresh_pkg::RATE_PIN_ADDR:     core_rdata_ff <= {8'h00, pin_sync2_ff,
          rise_flag_ff, fall_flag_ff, rate_en_ff, 1'b0};
        default:                              core_rdata_ff <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence s_reset_cmd;
    cmd_reset && !pin_rise && !pin_fall;
  endsequence

  property p_rise_set;
    @(posedge clock_in) disable iff (!reset_n_in) pin_rise |=> rise_flag_ff;
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rise flag missed");

  property p_flags_clear;
    @(posedge clock_in) disable iff (!reset_n_in)
      s_reset_cmd |=> !rise_flag_ff && !fall_flag_ff;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

  property p_both_enabled;
    @(posedge clock_in) disable iff (!reset_n_in)
      pin_rise && !cmd_full && rate_en_ff[3] && rate_en_ff[2]
      |=> update_ff && clear_ff && !activate_ff;
  endproperty
  a_both_enabled: assert property (p_both_enabled) else $error("wrong refresh kind");

  property p_retain_keeps;
    @(posedge clock_in) disable iff (!reset_n_in)
      lim_retain && !cmd_full |=> update_ff && !clear_ff && !activate_ff;
  endproperty
  a_retain_keeps: assert property (p_retain_keeps) else $error("retain cleared");

  property p_activate;
    @(posedge clock_in) disable iff (!reset_n_in)
      cmd_full |=> active_range_ff == $past(range_cfg_ff);
  endproperty
  a_activate: assert property (p_activate) else $error("range not activated");

  property p_no_activate;
    @(posedge clock_in) disable iff (!reset_n_in) !cmd_full |=> $stable(active_range_ff);
  endproperty
  a_no_activate: assert property (p_no_activate) else $error("range changed");

  property p_en_stable;
    @(posedge clock_in) disable iff (!reset_n_in) !wr_rate |=> $stable(rate_en_ff);
  endproperty
  a_en_stable: assert property (p_en_stable) else $error("enable moved");

  property p_rate_read;
    @(posedge clock_in) disable iff (!reset_n_in)
      is_read && hold_addr_ff == range_refresh_pkg::RATE_PIN_ADDR
      |=> !core_rdata_ff[0] && core_rdata_ff[7] == $past(pin_sync2_ff);
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate read wrong");

  property p_ready;
    @(posedge clock_in) disable iff (!reset_n_in)
      update_ff |-> !ready_ff ##1 !ready_ff;
  endproperty
  a_ready: assert property (p_ready) else $error("ready too early");
endmodule : range_refresh_rate_pin_control
`default_nettype wire

// ---- range_refresh_pkg.sv ----
// Constants for the range, refresh and rate-pin control block.
// Assumes a front end that turns bus transfers into single register accesses.
package range_refresh_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] PLAIN_REFRESH_ADDR  = 8'h00;
  localparam logic [7:0] RANGE_CFG_ADDR      = 8'h1D;
  localparam logic [7:0] GLOBAL_REFRESH_ADDR = 8'h1E;
  localparam logic [7:0] RETAIN_REFRESH_ADDR = 8'h1F;
  localparam logic [7:0] RATE_PIN_ADDR       = 8'h20;
  localparam logic [7:0] ACTIVE_RANGE_ADDR   = 8'h22;
  // ==========================================================
  // Fields and reset values
  localparam int unsigned SENSE_FIELD_TOP    = 15;
  localparam int unsigned BUSV_FIELD_TOP     = 7;
  localparam int unsigned PIN_LEVEL_BIT      = 7;
  localparam int unsigned RISE_FLAG_BIT      = 6;
  localparam int unsigned FALL_FLAG_BIT      = 5;
  localparam int unsigned EN_FIELD_LSB       = 1;
  localparam int unsigned FALL_RETAIN_EN     = 0;
  localparam int unsigned FALL_RESET_EN      = 1;
  localparam int unsigned RISE_RETAIN_EN     = 2;
  localparam int unsigned RISE_RESET_EN      = 3;
  localparam logic [15:0] RANGE_CFG_RESET    = 16'h0000;
  localparam logic [3:0]  RATE_EN_RESET      = 4'h0;
  // ==========================================================
  // Codes
  typedef enum logic [1:0] {
    RANGE_UNIPOLAR     = 2'b00,
    RANGE_BIPOLAR_FULL = 2'b01,
    RANGE_BIPOLAR_HALF = 2'b10,
    RANGE_RESERVED     = 2'b11
  } range_code_e;
  typedef enum logic [1:0] {
    ACC_READ  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_SEND  = 2'b10
  } acc_kind_e;
  // ==========================================================
  // Timing
  localparam int unsigned WAIT_W             = 18;
  localparam int unsigned CLOCK_PERIOD_NS    = 4;
  localparam int unsigned RESULT_WAIT_NS     = 1000000;
  localparam logic [WAIT_W-1:0] RESULT_WAIT_CYCLES =
    WAIT_W'(RESULT_WAIT_NS / CLOCK_PERIOD_NS);
endpackage : range_refresh_pkg

// ---- link_host_model.sv ----
// Behavioural host on the link access port of the range and refresh block.
// Assumes one access at a time and a free running link clock.
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
  // Link clock
  input  wire logic        link_clk_in,
  // Request to the block
  output logic             acc_req_out,
  output logic [1:0]       acc_kind_out,
  output logic [7:0]       acc_addr_out,
  output logic [15:0]      acc_wdata_out,
  // Answer from the block
  input  wire logic        acc_busy_in,
  input  wire logic        acc_done_in,
  input  wire logic [15:0] acc_rdata_in
);
  // ==========================================================
  // Idle levels
  initial begin
    acc_req_out   = 1'b0;
    acc_kind_out  = 2'h3;
    acc_addr_out  = 8'hFF;
    acc_wdata_out = 16'h0000;
  end
  // ==========================================================
  // One access; the request drops after acceptance, since a level left high
  // while done stands would be taken again as a second access.
  task automatic access(input logic [1:0] kind, input logic [7:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output bit ok);
    int n;
    bit busy_seen;
    ok    = 1'b0;
    rdata = {16{1'bx}};
    @(negedge link_clk_in);
    acc_req_out   <= 1'b1;
    acc_kind_out  <= kind;
    acc_addr_out  <= addr;
    acc_wdata_out <= wdata;
    @(negedge link_clk_in);
    acc_req_out   <= 1'b0;
    acc_kind_out  <= ~kind;
    acc_addr_out  <= ~addr;
    acc_wdata_out <= ~wdata;
    // Busy must stand after acceptance and drop with the answer.
    busy_seen = (acc_busy_in === 1'b1);
    for (n = 0; n < 12 && !ok; n++) begin
      @(negedge link_clk_in);
      if (acc_done_in === 1'b1) begin
        rdata = acc_rdata_in;
        ok    = busy_seen && (acc_busy_in === 1'b0);
      end
    end
  endtask : access
endmodule : link_host_model
`default_nettype wire

// ---- range_refresh_rate_pin_control_bench.sv ----
// Self-checking bench for the range, refresh and rate-pin control block.
// Assumes the link host model and a shortened result wait.
`timescale 1ns/1ps
`default_nettype none
module range_refresh_rate_pin_control_bench;
  localparam int unsigned RW = 20;
  logic clock_in = 1'b0, link_clk_in = 1'b0, reset_n_in = 1'b0, rate_pin_in = 1'b0;
  logic acc_req, acc_busy, acc_done, upd, clr, act, ready;
  logic [1:0] acc_kind;
  logic [7:0] acc_addr;
  logic [15:0] acc_wdata, acc_rdata, act_range;
  logic [3:0] s_bip, s_half, b_bip, b_half;
  int n_errors = 0, cmp_count = 0, n_upd = 0, n_clr = 0, n_act = 0;
  int low_run = 0, last_span = 0;
  logic [3:0] en_tab [8] = '{4'h0, 4'h8, 4'h8, 4'h1, 4'h4, 4'h2, 4'hC, 4'h3};
  logic [7:0] upd_tab = 8'hFC;
  logic [7:0] clr_tab = 8'hE4;
  // ==========================================================
  // Clocks, design and host
  always #2 clock_in = ~clock_in;
  initial #13 forever #40 link_clk_in = ~link_clk_in;
  range_refresh_rate_pin_control #(.RESULT_WAIT(range_refresh_pkg::WAIT_W'(RW))) dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .link_clk_in(link_clk_in),
    .link_reset_n_in(reset_n_in), .acc_req_in(acc_req), .acc_kind_in(acc_kind),
    .acc_addr_in(acc_addr), .acc_wdata_in(acc_wdata), .acc_busy_out(acc_busy),
    .acc_done_out(acc_done), .acc_rdata_out(acc_rdata), .rate_pin_in(rate_pin_in),
    .results_update_out(upd), .accum_clear_out(clr), .pending_activate_out(act),
    .results_ready_out(ready), .active_range_out(act_range),
    .sense_bipolar_out(s_bip), .sense_half_out(s_half),
    .busv_bipolar_out(b_bip), .busv_half_out(b_half));
  link_host_model host (
    .link_clk_in(link_clk_in), .acc_req_out(acc_req), .acc_kind_out(acc_kind),
    .acc_addr_out(acc_addr), .acc_wdata_out(acc_wdata), .acc_busy_in(acc_busy),
    .acc_done_in(acc_done), .acc_rdata_in(acc_rdata));
  // ==========================================================
  // Strobe counters and result-wait span
  always @(posedge clock_in) begin
    if (upd === 1'b1) n_upd++;
    if (clr === 1'b1) n_clr++;
    if (act === 1'b1) n_act++;
    if (ready === 1'b0) low_run++;
    else if (low_run != 0) begin
      last_span = low_run;
      low_run   = 0;
    end
  end
  // ==========================================================
  // Checks and accesses
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic [1:0] k, input logic [7:0] a, input logic [15:0] w,
                     output logic [15:0] r);
    bit ok;
    host.access(k, a, w, r, ok);
    chk("access answer", 16'h0001, {15'h0000, ok});
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    logic [15:0] r;
    acc(2'b01, a, w, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] r;
    acc(2'b00, a, 16'h0000, r);
    chk(nm, e, r);
  endtask : rd
  // Send a command, then wait out the result time before looking at results.
  task automatic cmd(input logic [7:0] code, input logic [15:0] e_clr);
    int u, c, a, n;
    logic [15:0] r;
    u = n_upd;
    c = n_clr;
    a = n_act;
    acc(2'b10, code, 16'h0000, r);
    for (n = 0; n < 4 * RW && ready !== 1'b1; n++) @(negedge clock_in);
    @(negedge clock_in);
    chk("update pulses", 16'h0001, 16'(n_upd - u));
    chk("clear pulses", e_clr, 16'(n_clr - c));
    chk("activate pulses", 16'h0001, 16'(n_act - a));
    chk("ready span ok", 16'h0001, 16'(last_span >= RW && last_span <= RW + 1));
  endtask : cmd
  function automatic logic [3:0] dec(input logic [7:0] f, input bit half);
    logic [3:0] r;
    logic [1:0] c;
    int k;
    for (k = 0; k < 4; k++) begin
      c    = f[7 - 2 * k -: 2];
      r[k] = half ? (c == 2'b10) : (c == 2'b01 || c == 2'b10);
    end
    return r;
  endfunction : dec
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ==========================================================
  // Watchdog; the tests need about a seventh of this span.
  initial begin
    #100000;
    n_errors++;
    $display("mismatch watchdog expected finish seen hang");
    summarize();
  end
  // ==========================================================
  // Tests
  initial begin
    int i, u, c, a;
    repeat (12) @(posedge link_clk_in);
    @(negedge clock_in) reset_n_in = 1'b1;
    repeat (2) @(posedge link_clk_in);
    rd(8'h1D, 16'h0000, "range reset");
    rd(8'h20, 16'h0000, "rate reset");
    rd(8'h22, 16'h0000, "active reset");
    rd(8'h05, 16'h0000, "unmapped read");
    chk("ready after reset", 16'h0001, {15'h0000, ready});
    $display("test reset done");
    wr(8'h1D, 16'h1BE4);
    wr(8'h05, 16'hFFFF);
    rd(8'h1D, 16'h1BE4, "range pending");
    rd(8'h22, 16'h0000, "active before refresh");
    chk("active out pending", 16'h0000, act_range);
    cmd(8'h1F, 16'h0000);
    rd(8'h22, 16'h1BE4, "active after refresh");
    chk("sense bipolar", {12'h000, dec(8'h1B, 1'b0)}, {12'h000, s_bip});
    chk("sense half", {12'h000, dec(8'h1B, 1'b1)}, {12'h000, s_half});
    chk("bus bipolar", {12'h000, dec(8'hE4, 1'b0)}, {12'h000, b_bip});
    chk("bus half", {12'h000, dec(8'hE4, 1'b1)}, {12'h000, b_half});
    cmd(8'h1E, 16'h0001);
    cmd(8'h00, 16'h0001);
    rd(8'h1E, 16'h0000, "command reads zero");
    $display("test range and commands done");
    wr(8'h1D, 16'h5A5A);
    for (i = 0; i < 8; i++) begin
      wr(8'h20, {8'h00, 3'b111, en_tab[i], 1'b1});
      u = n_upd;
      c = n_clr;
      a = n_act;
      @(negedge clock_in) rate_pin_in = ~i[0];
      repeat (12) @(negedge clock_in);
      chk("limited update", {15'h0000, upd_tab[i]}, 16'(n_upd - u));
      chk("limited clear", {15'h0000, clr_tab[i]}, 16'(n_clr - c));
      chk("limited activate", 16'h0000, 16'(n_act - a));
      rd(8'h20, {8'h00, ~i[0], 1'b1, i > 0, en_tab[i], 1'b0}, "rate state");
    end
    chk("active after limited", 16'h1BE4, act_range);
    cmd(8'h1F, 16'h0000);
    rd(8'h20, 16'h0066, "flags kept");
    chk("active activated", 16'h5A5A, act_range);
    cmd(8'h1E, 16'h0001);
    rd(8'h20, 16'h0006, "flags cleared");
    $display("test rate pin done");
    summarize();
  end
endmodule : range_refresh_rate_pin_control_bench
`default_nettype wire
